// file: design/timer_pkg.sv
/*
 * Package for the standard timer control core: register offsets, field
 * positions, reset values, mode and clock-select codes, and bus structs.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package timer_pkg;

    // =========================================================================
    // Register byte addresses.
    localparam logic [7:0] ctrl_first_off  = 8'h00;
    localparam logic [7:0] ctrl_second_off = 8'h04;
    localparam logic [7:0] count_low_off   = 8'h08;
    localparam logic [7:0] count_high_off  = 8'h0C;
    localparam logic [7:0] cmp_a_low_off   = 8'h10;
    localparam logic [7:0] cmp_a_high_off  = 8'h14;
    localparam logic [7:0] cmp_p_off       = 8'h18;

    // =========================================================================
    // Field positions.
    localparam int pause_pos     = 7;
    localparam int clk_sel_lsb   = 4;
    localparam int on_off_pos    = 3;
    localparam int mode_lsb      = 6;
    localparam int out_fn_lsb    = 4;
    localparam int init_lvl_pos  = 3;
    localparam int polarity_pos  = 2;
    localparam int swap_pos      = 1;
    localparam int clr_sel_pos   = 0;
    localparam logic [7:0] ctrl_first_mask = 8'hF8;

    // =========================================================================
    // Values after reset.
    localparam logic [7:0]  ctrl_reset  = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;

    // =========================================================================
    // Codes.
    typedef enum logic [1:0] {
        mode_compare = 2'h0,
        mode_capture = 2'h1,
        mode_pwm     = 2'h2,
        mode_timer   = 2'h3
    } mode_e;

    typedef enum logic [1:0] {
        fn_none   = 2'h0,
        fn_low    = 2'h1,
        fn_high   = 2'h2,
        fn_toggle = 2'h3
    } out_fn_e;

    typedef enum logic [2:0] {
        ck_sys_div4  = 3'h0,
        ck_sys       = 3'h1,
        ck_high_d16  = 3'h2,
        ck_high_d64  = 3'h3,
        ck_time_base = 3'h4,
        ck_high_d8   = 3'h5,
        ck_pin_rise  = 3'h6,
        ck_pin_fall  = 3'h7
    } clk_sel_e;

    localparam int sys_div4_cycles = 4;

    // =========================================================================
    // Bus carriers.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

// file: design/pin_sync.sv
/*
 * Two-flop synchroniser with edge detection on the settled copy.
 * Assumes the input is asynchronous to pclk.
 */
`timescale 1ns/1ps
module pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // =========================================================================
    // Only sync_q reads meta_q; edges are taken from the settled stages.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule

// file: design/standard_timer_control_core.sv
/*
 * Control core of the 16-bit standard timer: APB register file, clock source
 * selection, run/pause/on-off control of the counter, clear on comparator
 * match, and compare-match output pin logic.
 * Assumes the internal divided clocks arrive as one-cycle pclk-domain ticks
 * and the external clock pin is asynchronous.
 */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - Setting the pause bit halts the counter and clearing it resumes counting.
// - A paused counter keeps its value and resumes from it, not from zero.
// - The three-bit clock select picks sys/4, sys, high/16, high/64, time-base, high/8, pin rise or pin fall.
// - The on/off bit gates the timer; when low the counter stops.
// - A rising edge of the on/off bit clears the counter to zero.
// - A falling edge of the on/off bit leaves the counter holding its value.
// - In compare match mode a rising on/off edge sets the output pin to the initial level bit.
// - The three low bits of the first control register always read as zero.
// - Mode 10 is PWM or single pulse and mode 11 is timer/counter with the output pin unused.
module standard_timer_control_core (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire timer_pkg::apb_req_s apb_req,
    output timer_pkg::apb_rsp_s      apb_rsp,
    input  wire logic                high_div16_tick,
    input  wire logic                high_div64_tick,
    input  wire logic                high_div8_tick,
    input  wire logic                time_base_tick,
    input  wire logic                external_clock_pin,
    output logic                     timer_output_pin,
    output logic                     timer_output_oe,
    output logic [1:0]               mode_select,
    output logic [1:0]               output_function,
    output logic                     match_a,
    output logic                     match_p
);
    logic [7:0]  ctrl_first_q;
    logic [7:0]  ctrl_second_q;
    logic [15:0] count_q;
    logic [15:0] cmp_a_q;
    logic [7:0]  cmp_p_q;
    logic        on_prev_q;
    logic [1:0]  div4_q;
    logic        out_q;
    logic [31:0] rdata_q;
    logic        pin_rise;
    logic        pin_fall;
    logic        tick;
    logic        counting;
    logic        on_rise;
    logic        wr_en;
    logic        rd_en;
    logic        a_hit;
    logic        p_hit;
    logic        clr_on_a;

    wire logic counter_pause_bit  = ctrl_first_q[timer_pkg::pause_pos];
    wire logic timer_on_off_bit   = ctrl_first_q[timer_pkg::on_off_pos];
    wire logic [2:0] counter_clock_select = ctrl_first_q[timer_pkg::clk_sel_lsb +: 3];
    wire logic output_initial_level_bit   = ctrl_second_q[timer_pkg::init_lvl_pos];
    wire logic counter_clear_select_bit   = ctrl_second_q[timer_pkg::clr_sel_pos];

    // Address decode shared by the write and read paths.
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // =========================================================================
    // Bus slave: zero wait states, error on an unmapped address.
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    function automatic logic mapped(input logic [7:0] a);
        return addr_is(a, timer_pkg::ctrl_first_off) | addr_is(a, timer_pkg::ctrl_second_off)
             | addr_is(a, timer_pkg::count_low_off) | addr_is(a, timer_pkg::count_high_off)
             | addr_is(a, timer_pkg::cmp_a_low_off) | addr_is(a, timer_pkg::cmp_a_high_off)
             | addr_is(a, timer_pkg::cmp_p_off);
    endfunction

    always_comb begin
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped(apb_req.paddr);
        apb_rsp.prdata  = rdata_q;
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (1'b1)
                addr_is(apb_req.paddr, timer_pkg::ctrl_first_off):
                    rdata_q <= {24'h000000, ctrl_first_q & timer_pkg::ctrl_first_mask};
                addr_is(apb_req.paddr, timer_pkg::ctrl_second_off):
                    rdata_q <= {24'h000000, ctrl_second_q};
                addr_is(apb_req.paddr, timer_pkg::count_low_off):
                    rdata_q <= {24'h000000, count_q[7:0]};
                addr_is(apb_req.paddr, timer_pkg::count_high_off):
                    rdata_q <= {24'h000000, count_q[15:8]};
                addr_is(apb_req.paddr, timer_pkg::cmp_a_low_off):
                    rdata_q <= {24'h000000, cmp_a_q[7:0]};
                addr_is(apb_req.paddr, timer_pkg::cmp_a_high_off):
                    rdata_q <= {24'h000000, cmp_a_q[15:8]};
                addr_is(apb_req.paddr, timer_pkg::cmp_p_off):
                    rdata_q <= {24'h000000, cmp_p_q};
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================================
    // Control and compare registers. Bits 2..0 of the first are never stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_first_q  <= timer_pkg::ctrl_reset;
            ctrl_second_q <= timer_pkg::ctrl_reset;
            cmp_a_q       <= timer_pkg::count_reset;
            cmp_p_q       <= timer_pkg::ctrl_reset;
        end else if (wr_en) begin
            if (addr_is(apb_req.paddr, timer_pkg::ctrl_first_off)) begin
                ctrl_first_q <= apb_req.pwdata[7:0] & timer_pkg::ctrl_first_mask;
            end
            // Writing this while running is allowed but PWM output is then undefined.
            if (addr_is(apb_req.paddr, timer_pkg::ctrl_second_off)) begin
                ctrl_second_q <= apb_req.pwdata[7:0];
            end
            if (addr_is(apb_req.paddr, timer_pkg::cmp_a_low_off)) begin
                cmp_a_q[7:0] <= apb_req.pwdata[7:0];
            end
            if (addr_is(apb_req.paddr, timer_pkg::cmp_a_high_off)) begin
                cmp_a_q[15:8] <= apb_req.pwdata[7:0];
            end
            if (addr_is(apb_req.paddr, timer_pkg::cmp_p_off)) begin
                cmp_p_q <= apb_req.pwdata[7:0];
            end
        end
    end

    assign mode_select     = ctrl_second_q[timer_pkg::mode_lsb +: 2];
    assign output_function = ctrl_second_q[timer_pkg::out_fn_lsb +: 2];

    // =========================================================================
    // Clock source selection.
    pin_sync u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (external_clock_pin),
        .level    (),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div4_q <= 2'h0;
        end else begin
            div4_q <= div4_q + 2'h1;
        end
    end

    always_comb begin
        unique case (timer_pkg::clk_sel_e'(counter_clock_select))
            timer_pkg::ck_sys_div4:  tick = (div4_q == 2'(timer_pkg::sys_div4_cycles - 1));
            timer_pkg::ck_sys:       tick = 1'b1;
            timer_pkg::ck_high_d16:  tick = high_div16_tick;
            timer_pkg::ck_high_d64:  tick = high_div64_tick;
            timer_pkg::ck_time_base: tick = time_base_tick;
            timer_pkg::ck_high_d8:   tick = high_div8_tick;
            timer_pkg::ck_pin_rise:  tick = pin_rise;
            timer_pkg::ck_pin_fall:  tick = pin_fall;
        endcase
    end

    // =========================================================================
    // Counter.
    assign on_rise  = timer_on_off_bit & ~on_prev_q;
    assign counting = timer_on_off_bit & ~counter_pause_bit & tick;
    assign clr_on_a = counter_clear_select_bit & (mode_select != timer_pkg::mode_pwm);
    assign a_hit    = counting & (count_q == cmp_a_q);
    // A P value of FF matches only at wrap, i.e. plain 16-bit overflow.
    assign p_hit    = counting & (count_q[15:8] == cmp_p_q) & (count_q[7:0] == 8'hFF);
    assign match_a  = a_hit;
    assign match_p  = p_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= timer_on_off_bit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= timer_pkg::count_reset;
        end else if (on_rise) begin
            count_q <= timer_pkg::count_reset;
        end else if (counting) begin
            if ((clr_on_a & a_hit) | (~clr_on_a & p_hit)) begin
                count_q <= timer_pkg::count_reset;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
        // Paused or switched off: value is simply kept.
    end

    // =========================================================================
    // Output pin in compare match mode; unused in timer/counter mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else if (mode_select == timer_pkg::mode_compare) begin
            if (on_rise) begin
                out_q <= output_initial_level_bit;
            end else if (a_hit) begin
                unique case (timer_pkg::out_fn_e'(output_function))
                    timer_pkg::fn_none:   out_q <= out_q;
                    timer_pkg::fn_low:    out_q <= 1'b0;
                    timer_pkg::fn_high:   out_q <= 1'b1;
                    timer_pkg::fn_toggle: out_q <= ~out_q;
                endcase
            end
        end
    end

    assign timer_output_pin = out_q;
    assign timer_output_oe  = (mode_select != timer_pkg::mode_timer);

    // =========================================================================
    // Checks.
    a_pause_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (counter_pause_bit && $past(counter_pause_bit) && !on_rise) |-> $stable(count_q))
        else $error("counter moved while paused");
    a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!$past(timer_on_off_bit) && !on_rise) |-> $stable(count_q))
        else $error("counter moved while off");
    a_rise_clears: assert property (@(posedge pclk) disable iff (!presetn)
        on_rise |=> (count_q == 16'h0000))
        else $error("counter not cleared on enable");
    a_sys_counts: assert property (@(posedge pclk) disable iff (!presetn)
        (counting && counter_clock_select == 3'h1 && !a_hit && !p_hit && !on_rise)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("counter did not advance");
    a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
        (on_rise && mode_select == 2'h0) |=> (out_q == $past(output_initial_level_bit)))
        else $error("output not set to initial level");
    a_low_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_first_q[2:0] == 3'h0)
        else $error("unimplemented bits set");
    a_timer_no_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_select == 2'h3) |-> !timer_output_oe)
        else $error("pin driven in timer mode");
    a_toggle_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (a_hit && !on_rise && mode_select == 2'h0 && output_function == 2'h3)
        |=> (out_q != $past(out_q)))
        else $error("output did not toggle");
endmodule

// file: bench/ext_pin_model.sv
/*
 * Model of the external clock pin that feeds the timer's pin clock source.
 * Assumes the bench calls its tasks and that the pin is sampled on pclk.
 */
`timescale 1ns/1ps
module ext_pin_model (
    input  wire logic pclk,
    output logic      pin
);
    // =========================================================================
    // Pin driver.
    // Each level is held six cycles so that the two-flop synchroniser and its
    // edge detector settle before the bench looks at the counter.
    initial pin = 1'b0;

    task automatic drive(input logic v);
        @(posedge pclk);
        pin <= v;
        repeat (6) @(posedge pclk);
    endtask
endmodule

// file: bench/tb_top.sv
/*
 * Self-checking bench for the standard timer control core.
 * Assumes the APB slave and timing described in the designer's notes.
 */
`timescale 1ns/1ps
module tb_top;
    logic                pclk;
    logic                presetn;
    timer_pkg::apb_req_s req;
    timer_pkg::apb_rsp_s rsp;
    logic                t16, t64, t8, ttb;
    logic                ext_pin, out_pin, out_oe, ma, mp;
    logic [1:0]          mode, fn;
    logic [31:0]         rd;
    logic                err;
    logic [15:0]         cnt;
    int                  errors, checks;
    int                  ma_n, mp_n;

    // Match outputs are one-cycle pulses, so they are counted rather than sampled.
    always @(posedge pclk) begin
        if (ma === 1'b1) ma_n <= ma_n + 1;
        if (mp === 1'b1) mp_n <= mp_n + 1;
    end

    standard_timer_control_core standard_timer_control_core_inst (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .high_div16_tick(t16), .high_div64_tick(t64), .high_div8_tick(t8),
        .time_base_tick(ttb), .external_clock_pin(ext_pin),
        .timer_output_pin(out_pin), .timer_output_oe(out_oe),
        .mode_select(mode), .output_function(fn), .match_a(ma), .match_p(mp));
    ext_pin_model ext_pin_model_inst (.pclk(pclk), .pin(ext_pin));

    // =========================================================================
    // Shared tasks.
    task automatic report_and_stop();
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (rsp.pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            report_and_stop();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Lets the edge after a register write pass, then samples away from the edge.
    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic rd_count();
        apb(1'b0, timer_pkg::count_low_off, 8'h00);
        cnt[7:0] = rd[7:0];
        apb(1'b0, timer_pkg::count_high_off, 8'h00);
        cnt[15:8] = rd[7:0];
    endtask

    task automatic tk(input int i);
        @(posedge pclk);
        case (i)
            0: t16 <= 1'b1;
            1: t64 <= 1'b1;
            2: ttb <= 1'b1;
            default: t8 <= 1'b1;
        endcase
        @(posedge pclk);
        {t16, t64, ttb, t8} <= 4'h0;
    endtask

    // =========================================================================
    // Scenarios.
    task automatic t_regs();
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), 8'h00);
            chk("reset value", 16'h0000, rd[15:0]);
        end
        apb(1'b1, 8'h00, 8'hF7);
        apb(1'b0, 8'h00, 8'h00);
        chk("ctrl_first low bits", 16'h00F0, rd[15:0]);
        apb(1'b0, 8'h1C, 8'h00);
        chk_bit("unmapped error", 1'b1, err);
        chk("unmapped data", 16'h0000, rd[15:0]);
    endtask

    // Every tick input is pulsed a different number of times, so only the
    // selected source can produce the expected count.
    task automatic t_ticks();
        for (int s = 2; s < 6; s++) begin
            apb(1'b1, 8'h00, 8'h00);
            apb(1'b1, 8'h00, 8'((s << 4) | 8));
            for (int i = 0; i < 4; i++) repeat (i + 1) tk(i);
            rd_count();
            chk("tick count", 16'(s - 1), cnt);
        end
    endtask

    task automatic t_sys();
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, 8'h00, 8'h00);
            apb(1'b1, 8'h00, 8'((s << 4) | 8));
            repeat (40) @(posedge pclk);
            apb(1'b1, 8'h00, 8'((s << 4) | 8'h88));
            rd_count();
            chk_bit("sys count range", 1'b1,
                    cnt >= 16'(40 / (s ? 1 : 4) - 1) && cnt <= 16'(48 / (s ? 1 : 4)));
        end
    endtask

    task automatic t_pin();
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h00, 8'h68);
        ext_pin_model_inst.drive(1'b1);
        ext_pin_model_inst.drive(1'b0);
        rd_count();
        chk("rise count", 16'h0001, cnt);
        apb(1'b1, 8'h00, 8'hE8);
        ext_pin_model_inst.drive(1'b1);
        ext_pin_model_inst.drive(1'b0);
        rd_count();
        chk("paused count", 16'h0001, cnt);
        apb(1'b1, 8'h00, 8'h68);
        ext_pin_model_inst.drive(1'b1);
        rd_count();
        chk("resumed count", 16'h0002, cnt);
        apb(1'b1, 8'h00, 8'h60);
        ext_pin_model_inst.drive(1'b0);
        ext_pin_model_inst.drive(1'b1);
        apb(1'b1, timer_pkg::count_low_off, 8'hAA);
        rd_count();
        chk("held when off", 16'h0002, cnt);
        apb(1'b1, 8'h00, 8'h78);
        rd_count();
        chk("cleared on enable", 16'h0000, cnt);
        ext_pin_model_inst.drive(1'b0);
        rd_count();
        chk("fall count", 16'h0001, cnt);
    endtask

    task automatic t_out();
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, 8'h08);
        apb(1'b1, 8'h00, 8'h08);
        settle();
        chk_bit("initial high", 1'b1, out_pin);
        chk_bit("compare oe", 1'b1, out_oe);
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, 8'h31);
        apb(1'b1, timer_pkg::cmp_a_low_off, 8'h03);
        apb(1'b1, timer_pkg::cmp_a_high_off, 8'h00);
        settle();
        chk("function field", 16'h0003, 16'(fn));
        apb(1'b1, 8'h00, 8'h68);
        settle();
        chk_bit("initial low", 1'b0, out_pin);
        ma_n = 0;
        repeat (4) begin
            ext_pin_model_inst.drive(1'b1);
            ext_pin_model_inst.drive(1'b0);
        end
        chk_bit("pin after toggle", 1'b1, out_pin);
        chk("match a pulses", 16'h0001, 16'(ma_n));
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, 8'hC0);
        settle();
        chk("mode field", 16'h0003, 16'(mode));
        chk_bit("timer mode oe", 1'b0, out_oe);
        mp_n = 0;
        apb(1'b1, 8'h00, 8'h18);
        repeat (300) @(posedge pclk);
        chk("match p pulses", 16'h0001, 16'(mp_n));
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, 8'h80);
        settle();
        chk_bit("pwm mode oe", 1'b1, out_oe);
    endtask

    // =========================================================================
    // Clock, reset and main sequence.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        errors = 0;
        checks = 0;
        ma_n = 0;
        mp_n = 0;
        presetn = 1'b0;
        req = '0;
        {t16, t64, ttb, t8} = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ticks();
        t_sys();
        t_pin();
        t_out();
        report_and_stop();
    end
endmodule
